// ---- common/speed_ref_defs.svh ----
// constants for the speed reference ramp sequencer
`ifndef SPEED_REF_DEFS_SVH
`define SPEED_REF_DEFS_SVH

`define CLK_MHZ     200
`define TICK_US     1000
`define SPD_W       16
`define FRAC_W      8
`define ACC_W       24

// current mode thresholds in microamps
`define I_FAIL_LO   16'h07D0
`define I_FAIL_HI   16'h5208
`define I_SPAN_LO   16'h0FA0
`define I_SPAN_HI   16'h4E20
`define I_RECIP     16'h1062
// voltage mode thresholds in millivolts
`define V_FAIL_LO   16'h01F4
`define V_FAIL_HI   16'h1482
`define V_SPAN_LO   16'h03E8
`define V_SPAN_HI   16'h1388
`define V_RECIP     16'h4189
`define RECIP_SH    10
`define FRAC16_SH   16

`define RST_SPD     16'h0000
`define RST_CNT     32'h0000_0000
`define RST_SYNC    4'h0

`endif

// ---- common/speed_ref_pkg.sv ----
// types for the speed reference ramp sequencer
`include "speed_ref_defs.svh"
package speed_ref_pkg;
    typedef enum logic [2:0] {
        ST_INIT, ST_START, ST_IDLE, ST_ACCEL, ST_RATED, ST_DECEL
    } seq_st_t;

    typedef struct packed {
        seq_st_t                st;
        logic [3:0]             sync1;
        logic [3:0]             sync2;
        logic [31:0]            tick_cnt;
        logic [31:0]            warm_cnt;
        logic                   warm_done;
        logic                   analog_fail;
        logic                   remote_act;
        logic                   permissive;
        logic                   at_rated;
    } seq_state_t;

    typedef struct packed {
        logic [`ACC_W-1:0]      acc;
    } ramp_state_t;
endpackage

// ---- verif/remote_source.sv ----
// behavioural remote transmitter feeding the analog reference
`timescale 1ns/1ps
module remote_source (
    input  wire logic        clk,       // system clock
    input  wire logic        volt_mode, // 1..5 V transmitter
    input  wire logic [15:0] ua_cmd,    // loop current, uA
    output logic      [15:0] analog_in  // sample, uA or mV
);
    // 4 mA equals 1 V, so mV is a quarter of uA; one clock of lag
    always_ff @(posedge clk) begin
        analog_in <= volt_mode ? ua_cmd >> 2 : ua_cmd;
    end
endmodule

// ---- verif/speed_ref_seq_properties.sv ----
// port-level checks for the speed reference sequencer
`timescale 1ns/1ps
module speed_ref_seq_props (
    input wire logic        clk,          // system clock
    input wire logic        sys_rst,      // sync reset
    input wire logic        rated_in,     // rated contact
    input wire logic        remote_in,    // remote select
    input wire logic [15:0] low_lim,      // lower limit
    input wire logic [15:0] raise_lim,    // raise limit
    input wire logic [15:0] oil_temp,     // oil temperature
    input wire logic [15:0] perm_temp,    // permissive temperature
    input wire logic        temp_failed,  // sensor failed
    input wire logic        use_rmt_ref,  // remote ref enabled
    input wire logic        use_rmt_cmd,  // modbus source
    input wire logic        hold_on_fail, // freeze option
    input wire logic        volt_mode,    // millivolt input
    input wire logic [15:0] analog_in,    // analog sample
    input wire logic        mb_link_err,  // link error
    input wire logic [15:0] speed_ref,    // reference out
    input wire logic        analog_fail,  // fail flag
    input wire logic        remote_act,   // remote in control
    input wire logic        permissive,   // ramp permitted
    input wire logic        at_rated      // rated state
);
    logic fail_c;

    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    // out-of-range window of the analog input in either mode
    assign fail_c = volt_mode
        ? (analog_in < 16'h01F4 || analog_in > 16'h1482)
        : (analog_in < 16'h07D0 || analog_in > 16'h5208);

    // contacts pass a 2-stage sync, so allow a few cycles of lag
    sequence rated_drop_s;
        (!rated_in)[*3] ##0 at_rated;
    endsequence
    sequence remote_off_s;
        (remote_in && rated_in && !use_rmt_ref)[*4] ##0 at_rated;
    endsequence
    // raw window, as the sequencer itself decides on it, not the flag
    sequence hold_fail_s;
        (remote_act && at_rated && hold_on_fail &&
         (use_rmt_cmd ? mb_link_err : fail_c))[*3];
    endsequence

    fail_flag_a: assert property (
        !$past(sys_rst) |-> analog_fail == $past(fail_c))
        else $error("analog fail flag wrong");
    perm_temp_a: assert property (
        !temp_failed && $signed(oil_temp) > $signed(perm_temp)
        |=> permissive)
        else $error("permissive not raised");
    idle_hold_a: assert property (
        (!permissive)[*2] |=> !$rose(at_rated))
        else $error("rated reached without permissive");
    hold_freeze_a: assert property (
        hold_fail_s |=> $stable(speed_ref))
        else $error("reference moved while frozen");
    local_block_a: assert property (
        remote_off_s |=> $stable(speed_ref))
        else $error("local command taken in remote");
    upper_clamp_a: assert property (
        at_rated && speed_ref <= raise_lim
        |=> !at_rated || speed_ref <= raise_lim)
        else $error("reference above raise limit");
    lower_clamp_a: assert property (
        at_rated && speed_ref >= low_lim
        |=> !at_rated || speed_ref >= low_lim)
        else $error("reference below lower limit");
    decel_start_a: assert property (
        rated_drop_s |-> ##[0:3] !at_rated)
        else $error("rated not left on idle select");
    // contacts lag two sync stages plus the output register
    remote_gate_a: assert property (
        !$past(sys_rst, 3) |-> remote_act == ($past(remote_in, 3) &&
        $past(rated_in, 3) && $past(use_rmt_ref)))
        else $error("remote control gating wrong");
endmodule

// ---- verif/speed_ref_seq_tb.sv ----
// self-checking bench for the speed reference sequencer
`timescale 1ns/1ps
module speed_ref_seq_tb;
    logic        clk, sys_rst, rated_in, raise_in, lower_in, remote_in;
    logic [15:0] start_sp, idle_sp, rated_sp, low_lim, raise_lim;
    logic [15:0] rmt_lo_sp, rmt_hi_sp, oil_temp, perm_temp, ua_cmd;
    logic [15:0] accel_step, decel_step, raise_step, lower_step;
    logic [15:0] analog_in, mb_value, mb_default, speed_ref, held;
    logic [31:0] warmup_ticks;
    logic        temp_failed, use_rmt_ref, use_rmt_cmd, hold_on_fail;
    logic        volt_mode, mb_link_err, analog_fail, remote_act;
    logic        permissive, at_rated;
    int          n_mismatch, compares, cyc, ua, t0;

    speed_ref_seq #(.TICK_CYCLES(4)) i_speed_ref_seq (
        .clk(clk), .sys_rst(sys_rst), .rated_in(rated_in),
        .raise_in(raise_in), .lower_in(lower_in), .remote_in(remote_in),
        .start_sp(start_sp), .idle_sp(idle_sp), .rated_sp(rated_sp),
        .low_lim(low_lim), .raise_lim(raise_lim), .rmt_lo_sp(rmt_lo_sp),
        .rmt_hi_sp(rmt_hi_sp), .accel_step(accel_step),
        .decel_step(decel_step), .raise_step(raise_step),
        .lower_step(lower_step), .oil_temp(oil_temp),
        .perm_temp(perm_temp), .temp_failed(temp_failed),
        .warmup_ticks(warmup_ticks), .use_rmt_ref(use_rmt_ref),
        .use_rmt_cmd(use_rmt_cmd), .hold_on_fail(hold_on_fail),
        .volt_mode(volt_mode), .analog_in(analog_in),
        .mb_value(mb_value), .mb_default(mb_default),
        .mb_link_err(mb_link_err), .speed_ref(speed_ref),
        .analog_fail(analog_fail), .remote_act(remote_act),
        .permissive(permissive), .at_rated(at_rated));
    remote_source i_remote_source (.clk(clk), .volt_mode(volt_mode),
        .ua_cmd(ua_cmd), .analog_in(analog_in));

    // free-running cycle count for ramp timing
    always @(posedge clk) cyc <= cyc + 1;

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // stop near the target, then two more ticks for the last step
    task automatic wait_near(input logic [15:0] t, input int lim);
        for (int i = 0; i < lim; i++) begin
            if (speed_ref + 16'h0001 >= t && speed_ref <= t + 16'h0001)
                break;
            @(posedge clk);
        end
        repeat (8) @(posedge clk);
    endtask

    // straight line between endpoint speeds, clipped to 4..20 mA
    function automatic logic [15:0] interp(input int u);
        int c;
        c = u < 16'h0FA0 ? 16'h0FA0 : (u > 16'h4E20 ? 16'h4E20 : u);
        return 16'(int'(rmt_lo_sp) + (int'(rmt_hi_sp) - int'(rmt_lo_sp))
            * (c - 16'h0FA0) / 16'h3E80);
    endfunction

    function automatic logic [15:0] near(input logic [15:0] t);
        return {15'h0000, speed_ref + 16'h0001 >= t &&
                speed_ref <= t + 16'h0001};
    endfunction

    task automatic end_sim();
        $display("compares=%0d mismatches=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // watchdog, several times the expected run length
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        end_sim();
    end

    initial begin
        cyc = 0;
        sys_rst = 1'b1;
        {rated_in, raise_in, lower_in, remote_in} = 4'h0;
        // idle not above rated, endpoints inside the limits
        start_sp = 16'h0064; idle_sp = 16'h012C; rated_sp = 16'h0384;
        low_lim = 16'h0258; raise_lim = 16'h044C;
        rmt_lo_sp = 16'h02BC; rmt_hi_sp = 16'h03E8;
        accel_step = 16'h1400; decel_step = 16'h1400;
        raise_step = 16'h0A00; lower_step = 16'h0A00;
        oil_temp = 16'h000A; perm_temp = 16'h0032; temp_failed = 1'b0;
        warmup_ticks = 32'h0000_FFFF; ua_cmd = 16'h2EE0;
        {use_rmt_ref, use_rmt_cmd, hold_on_fail, volt_mode} = 4'h0;
        mb_value = 16'h0320; mb_default = 16'h028A; mb_link_err = 1'b0;
        ua = $urandom(72790);
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        // start to idle, then rated held off while cold
        wait_near(idle_sp, 200);
        check(speed_ref, idle_sp);
        rated_in <= 1'b1;
        repeat (200) @(posedge clk);
        check(speed_ref, idle_sp);
        check({15'h0000, at_rated}, 16'h0000);
        $display("test 1 done");
        // very low permissive setting lets the cold engine go
        perm_temp <= 16'h8000;
        t0 = cyc;
        for (int i = 0; i < 600 && at_rated !== 1'b1; i++) @(posedge clk);
        check(speed_ref, rated_sp);
        check({15'h0000, (cyc - t0) >= 116}, 16'h0001);
        $display("test 2 done");
        raise_in <= 1'b1;
        wait_near(raise_lim, 400);
        check(speed_ref, raise_lim);
        raise_in <= 1'b0;
        lower_in <= 1'b1;
        wait_near(low_lim, 400);
        check(speed_ref, low_lim);
        lower_in <= 1'b0;
        remote_in <= 1'b1;
        repeat (4) @(posedge clk);
        raise_in <= 1'b1;
        repeat (60) @(posedge clk);
        check(speed_ref, low_lim);
        raise_in <= 1'b0;
        $display("test 3 done");
        // analog remote, full-scale corner then random points
        use_rmt_ref <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            ua = k == 0 ? 20000 : 4000 + 4 * ($urandom % 4001);
            volt_mode <= k == 3;
            ua_cmd <= 16'(ua);
            wait_near(interp(ua), 400);
            check(near(interp(ua)), 16'h0001);
        end
        volt_mode <= 1'b0;
        $display("test 4 done");
        hold_on_fail <= 1'b1;
        ua_cmd <= 16'h05DC;
        repeat (4) @(posedge clk);
        check({15'h0000, analog_fail}, 16'h0001);
        held = speed_ref;
        repeat (60) @(posedge clk);
        check(speed_ref, held);
        hold_on_fail <= 1'b0;
        wait_near(rmt_lo_sp, 400);
        check(speed_ref, rmt_lo_sp);
        ua_cmd <= 16'h55F0;
        wait_near(rmt_hi_sp, 400);
        check(near(rmt_hi_sp), 16'h0001);
        $display("test 5 done");
        // modbus source, out-of-limit value and link failures
        use_rmt_cmd <= 1'b1;
        mb_value <= 16'h05DC;
        wait_near(raise_lim, 400);
        check(speed_ref, raise_lim);
        mb_link_err <= 1'b1;
        wait_near(mb_default, 400);
        check(speed_ref, mb_default);
        hold_on_fail <= 1'b1;
        mb_default <= 16'h0384;
        held = speed_ref;
        repeat (60) @(posedge clk);
        check(speed_ref, held);
        {mb_link_err, hold_on_fail} <= 2'b00;
        mb_value <= 16'h0320;
        $display("test 6 done");
        rated_in <= 1'b0;
        wait_near(idle_sp, 600);
        check(speed_ref, idle_sp);
        rated_in <= 1'b1;
        for (int i = 0; i < 600 && at_rated !== 1'b1; i++) @(posedge clk);
        check(speed_ref, mb_value);
        remote_in <= 1'b0;
        rated_in <= 1'b0;
        wait_near(idle_sp, 600);
        rated_in <= 1'b1;
        repeat (60) @(posedge clk);
        lower_in <= 1'b1;
        repeat (3) @(posedge clk);
        lower_in <= 1'b0;
        repeat (20) @(posedge clk);
        check({15'h0000, at_rated}, 16'h0001);
        check({15'h0000, speed_ref < rated_sp}, 16'h0001);
        $display("test 7 done");
        // failed sensor holds idle until the backup timer runs out
        perm_temp <= 16'h0032;
        temp_failed <= 1'b1;
        rated_in <= 1'b0;
        wait_near(idle_sp, 600);
        rated_in <= 1'b1;
        repeat (40) @(posedge clk);
        check({15'h0000, at_rated}, 16'h0000);
        warmup_ticks <= 32'h0000_0001;
        for (int i = 0; i < 600 && at_rated !== 1'b1; i++) @(posedge clk);
        check(speed_ref, rated_sp);
        $display("test 8 done");
        end_sim();
    end
endmodule

bind speed_ref_seq speed_ref_seq_props i_speed_ref_seq_props (
    .clk(clk), .sys_rst(sys_rst), .rated_in(rated_in),
    .remote_in(remote_in), .low_lim(low_lim), .raise_lim(raise_lim),
    .oil_temp(oil_temp), .perm_temp(perm_temp),
    .temp_failed(temp_failed), .use_rmt_ref(use_rmt_ref),
    .use_rmt_cmd(use_rmt_cmd), .hold_on_fail(hold_on_fail),
    .volt_mode(volt_mode), .analog_in(analog_in),
    .mb_link_err(mb_link_err), .speed_ref(speed_ref),
    .analog_fail(analog_fail), .remote_act(remote_act),
    .permissive(permissive), .at_rated(at_rated));

// ---- verilog/ramp_step.sv ----
// fixed-point ramp accumulator stepping toward a target
`timescale 1ns/1ps
`include "speed_ref_defs.svh"
module ramp_step (
    input  wire logic                 clk,       // system clock
    input  wire logic                 sys_rst,   // sync reset, high
    input  wire logic                 step_en,   // one step per tick
    input  wire logic                 load,      // force accumulator
    input  wire logic [`SPD_W-1:0]    load_val,  // value for load
    input  wire logic [`SPD_W-1:0]    target,    // speed to approach
    input  wire logic [`SPD_W-1:0]    up_step,   // increment, 1/256 rpm
    input  wire logic [`SPD_W-1:0]    down_step, // decrement, 1/256 rpm
    output logic      [`ACC_W-1:0]    acc_r      // accumulator
);
    import speed_ref_pkg::*;

    ramp_state_t s_r;
    ramp_state_t s_nxt;
    logic [`ACC_W-1:0] tgt_fx;
    logic [`ACC_W-1:0] gap;
    logic [`ACC_W-1:0] up_fx;
    logic [`ACC_W-1:0] dn_fx;

    // step is limited to the remaining gap so the ramp never overshoots
    always_comb begin
        s_nxt  = s_r;
        tgt_fx = {target, {`FRAC_W{1'b0}}};
        up_fx  = {{(`ACC_W-`SPD_W){1'b0}}, up_step};
        dn_fx  = {{(`ACC_W-`SPD_W){1'b0}}, down_step};
        gap    = '0;
        if (load) begin
            s_nxt.acc = {load_val, {`FRAC_W{1'b0}}};
        end else if (step_en) begin
            if (s_r.acc < tgt_fx) begin
                gap       = tgt_fx - s_r.acc;
                s_nxt.acc = s_r.acc + ((up_fx < gap) ? up_fx : gap);
            end else begin
                gap       = s_r.acc - tgt_fx;
                s_nxt.acc = s_r.acc - ((dn_fx < gap) ? dn_fx : gap);
            end
        end
    end

    // state register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_r.acc <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign acc_r = s_r.acc;
endmodule

// ---- verilog/speed_ref_seq.sv ----
// speed reference sequencer: idle, accel, rated, remote and decel
`timescale 1ns/1ps
`include "speed_ref_defs.svh"
module speed_ref_seq #(
    parameter int TICK_CYCLES = `TICK_US * `CLK_MHZ  // cycles per ramp tick
) (
    input  wire logic              clk,           // 200 MHz clock
    input  wire logic              sys_rst,       // sync reset, high
    input  wire logic              rated_in,      // rated contact, pin
    input  wire logic              raise_in,      // raise contact, pin
    input  wire logic              lower_in,      // lower contact, pin
    input  wire logic              remote_in,     // remote select, pin
    input  wire logic [15:0]       start_sp,      // start speed, rpm
    input  wire logic [15:0]       idle_sp,       // idle speed, rpm
    input  wire logic [15:0]       rated_sp,      // rated speed, rpm
    input  wire logic [15:0]       low_lim,       // lower limit, rpm
    input  wire logic [15:0]       raise_lim,     // raise limit, rpm
    input  wire logic [15:0]       rmt_lo_sp,     // speed at 4 mA
    input  wire logic [15:0]       rmt_hi_sp,     // speed at 20 mA
    input  wire logic [15:0]       accel_step,    // per tick, 1/256 rpm
    input  wire logic [15:0]       decel_step,    // per tick, 1/256 rpm
    input  wire logic [15:0]       raise_step,    // per tick, 1/256 rpm
    input  wire logic [15:0]       lower_step,    // per tick, 1/256 rpm
    input  wire logic [15:0]       oil_temp,      // oil temp, signed
    input  wire logic [15:0]       perm_temp,     // permissive, signed
    input  wire logic              temp_failed,   // thermocouple bad
    input  wire logic [31:0]       warmup_ticks,  // backup timer, ticks
    input  wire logic              use_rmt_ref,   // remote ref enabled
    input  wire logic              use_rmt_cmd,   // modbus source
    input  wire logic              hold_on_fail,  // freeze on failure
    input  wire logic              volt_mode,     // analog in mV
    input  wire logic [15:0]       analog_in,     // uA or mV sample
    input  wire logic [15:0]       mb_value,      // modbus speed, rpm
    input  wire logic [15:0]       mb_default,    // modbus default, rpm
    input  wire logic              mb_link_err,   // modbus link error
    output logic      [15:0]       speed_ref,     // speed reference
    output logic                   analog_fail,   // analog in failed
    output logic                   remote_act,    // remote in control
    output logic                   permissive,    // ramp permitted
    output logic                   at_rated       // rated operation
);
    import speed_ref_pkg::*;

    seq_state_t        s_r;
    seq_state_t        s_nxt;
    logic              tick;
    logic              rated_c;
    logic              raise_c;
    logic              lower_c;
    logic              remote_c;
    logic              afail_now;
    logic              rfail;
    logic              reached;
    logic              ramp_load;
    logic [15:0]       tgt;
    logic [15:0]       up;
    logic [15:0]       dn;
    logic [15:0]       x_clip;
    logic [15:0]       span_lo;
    logic [15:0]       span_hi;
    logic [31:0]       frac_prod;
    logic [16:0]       frac16;
    logic signed [17:0] span;
    logic signed [35:0] interp;
    logic signed [17:0] atgt_raw;
    logic [15:0]       atgt;
    logic [15:0]       rtgt;
    logic [`ACC_W-1:0] acc;

    // limit a signed candidate speed into the lower/raise window
    function automatic logic [15:0] clamp_spd(input logic signed [17:0] v,
                                              input logic [15:0] lo,
                                              input logic [15:0] hi);
        if (v < $signed({2'b00, lo})) begin
            clamp_spd = lo;
        end else if (v > $signed({2'b00, hi})) begin
            clamp_spd = hi;
        end else begin
            clamp_spd = v[15:0];
        end
    endfunction

    // contact levels after the two-stage synchroniser
    assign rated_c  = s_r.sync2[3];
    assign raise_c  = s_r.sync2[2];
    assign lower_c  = s_r.sync2[1];
    assign remote_c = s_r.sync2[0];
    assign tick     = (s_r.tick_cnt == 32'(TICK_CYCLES - 1));
    assign reached  = (acc == {tgt, {`FRAC_W{1'b0}}});

    // remote analog decode, the failed value is still followed clipped
    always_comb begin
        span_lo = volt_mode ? `V_SPAN_LO : `I_SPAN_LO;
        span_hi = volt_mode ? `V_SPAN_HI : `I_SPAN_HI;
        if (volt_mode) begin
            afail_now = (analog_in < `V_FAIL_LO) || (analog_in > `V_FAIL_HI);
        end else begin
            afail_now = (analog_in < `I_FAIL_LO) || (analog_in > `I_FAIL_HI);
        end
        if (analog_in < span_lo) begin
            x_clip = span_lo;
        end else if (analog_in > span_hi) begin
            x_clip = span_hi;
        end else begin
            x_clip = analog_in;
        end
        // straight line between endpoints
        // reciprocal multiply replaces a divider and truncates, so the result can come out a count low
        frac_prod = (x_clip - span_lo) * (volt_mode ? `V_RECIP : `I_RECIP);
        frac16    = {1'b0, frac_prod[`RECIP_SH +: 16]};
        span      = $signed({2'b00, rmt_hi_sp}) - $signed({2'b00, rmt_lo_sp});
        interp    = span * $signed(frac16);
        atgt_raw  = $signed({2'b00, rmt_lo_sp})
                  + 18'(interp >>> `FRAC16_SH);
        atgt = clamp_spd(atgt_raw, low_lim, raise_lim);
        if (use_rmt_cmd) begin
            rtgt = mb_link_err
                 ? clamp_spd($signed({2'b00, mb_default}), low_lim, raise_lim)
                 : clamp_spd($signed({2'b00, mb_value}), low_lim, raise_lim);
            rfail = mb_link_err;
        end else begin
            rtgt  = atgt;
            rfail = afail_now;
        end
    end

    // sequencer: next state and ramp command
    always_comb begin
        s_nxt       = s_r;
        ramp_load   = 1'b0;
        tgt         = acc[`ACC_W-1:`FRAC_W];
        up          = '0;
        dn          = '0;
        s_nxt.sync1 = {rated_in, raise_in, lower_in, remote_in};
        s_nxt.sync2 = s_r.sync1;
        s_nxt.tick_cnt = tick ? `RST_CNT : s_r.tick_cnt + 32'h1;
        if (tick && !s_r.warm_done) begin
            s_nxt.warm_cnt = s_r.warm_cnt + 32'h1;
        end
        s_nxt.warm_done = (s_r.warm_cnt >= warmup_ticks);
        s_nxt.permissive = s_r.warm_done || (!temp_failed &&
                           ($signed(oil_temp) > $signed(perm_temp)));
        s_nxt.analog_fail = afail_now;
        s_nxt.remote_act = remote_c && rated_c && use_rmt_ref;
        case (s_r.st)
            ST_INIT: begin
                ramp_load = 1'b1;
                s_nxt.st  = ST_START;
            end
            ST_START: begin
                tgt = idle_sp;
                up  = accel_step;
                dn  = accel_step;
                if (reached) begin
                    s_nxt.st = ST_IDLE;
                end
            end
            ST_IDLE: begin
                tgt = idle_sp;
                up  = accel_step;
                dn  = decel_step;
                if (rated_c && s_r.permissive) begin
                    s_nxt.st = ST_ACCEL;
                end
            end
            ST_ACCEL: begin
                if (s_r.remote_act) begin
                    tgt = rtgt;
                    up  = raise_step;
                    dn  = lower_step;
                end else begin
                    tgt = rated_sp;
                    up  = accel_step;
                    dn  = accel_step;
                end
                if (!rated_c) begin
                    s_nxt.st = ST_DECEL;
                end else if (raise_c || lower_c) begin
                    tgt      = acc[`ACC_W-1:`FRAC_W];
                    up       = '0;
                    dn       = '0;
                    s_nxt.st = ST_RATED;
                end else if (reached) begin
                    s_nxt.st = ST_RATED;
                end
            end
            ST_RATED: begin
                if (!rated_c) begin
                    s_nxt.st = ST_DECEL;
                end else if (s_r.remote_act) begin
                    if (!(rfail && hold_on_fail)) begin
                        tgt = rtgt;
                        up  = raise_step;
                        dn  = lower_step;
                    end
                end else if (!remote_c && (raise_c != lower_c)) begin
                    tgt = raise_c ? raise_lim : low_lim;
                    up  = raise_c ? raise_step : 16'h0000;
                    dn  = raise_c ? 16'h0000 : lower_step;
                end
            end
            ST_DECEL: begin
                tgt = idle_sp;
                up  = decel_step;
                dn  = decel_step;
                if (rated_c && s_r.permissive) begin
                    s_nxt.st = ST_ACCEL;
                end else if (reached) begin
                    s_nxt.st = ST_IDLE;
                end
            end
            default: begin
                s_nxt.st = ST_INIT;
            end
        endcase
        s_nxt.at_rated = (s_nxt.st == ST_RATED);
    end

    // state register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_r.st          <= ST_INIT;
            s_r.sync1       <= `RST_SYNC;
            s_r.sync2       <= `RST_SYNC;
            s_r.tick_cnt    <= `RST_CNT;
            s_r.warm_cnt    <= `RST_CNT;
            s_r.warm_done   <= 1'b0;
            s_r.analog_fail <= 1'b0;
            s_r.remote_act  <= 1'b0;
            s_r.permissive  <= 1'b0;
            s_r.at_rated    <= 1'b0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // reference accumulator, steps once per tick
    ramp_step u_ramp (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .step_en   (tick),
        .load      (ramp_load),
        .load_val  (start_sp),
        .target    (tgt),
        .up_step   (up),
        .down_step (dn),
        .acc_r     (acc)
    );

    assign speed_ref   = acc[`ACC_W-1:`FRAC_W];
    assign analog_fail = s_r.analog_fail;
    assign remote_act  = s_r.remote_act;
    assign permissive  = s_r.permissive;
    assign at_rated    = s_r.at_rated;
endmodule
